// File: rtl/sfp_top.sv
// Serial flash pin front end: framing, shifting, protection and arrays.
// Assumes pins arrive asynchronously and SCK is far slower than clk.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Select falling edge starts a new command frame.
// - Select rising edge closes the frame; completed commands execute then.
// - Output enable stays off whenever select is high.
// - Serial input is ignored while deselected.
// - Deselected device shows standby once no program or erase runs, never deep power-down.
// - A running program or erase continues after select rises.
// - Command, address and write data sampled on SCK rising edges.
// - Output bits launched on SCK falling edges.
// - Write-protect low shields guarded sectors regardless of guard enable; here it blocks program and erase in every sector.
// - Guard map cannot change while write-protect is low.
// - Program or erase under write-protect is discarded, nothing done.
// - A discarded command returns to idle when select rises.
// - Guard enable and sector freeze still work under write-protect.
// - Undriven write-protect counts as high.
// - Reset pin low aborts everything and forces idle.
// - Reset holds while pin low, resumes once it is high.
// - Built-in power-on reset; reset pin needs no sequencing.
// - Main array is 2048 pages of 256 or 264 bytes.
// - Two page buffers accept host data during array programming.
// - Program and erase cycles are timed internally.
// - Frame carries an 8-bit opcode then the needed address bytes.
// - All bytes shift most significant bit first.
module sfp_top #(
  parameter int PAGES    = sfp_pkg::NUM_PAGES,
  parameter int PROG_CYC = sfp_pkg::PROG_CYCLES
) (
  input  logic               clk,
  input  logic               rst,
  input  sfp_pkg::sfp_pins_s pins,
  input  logic               pg_size_256,
  output logic               so,
  output logic               so_oe_n,
  output logic               standby,
  output logic               busy
);
  import sfp_pkg::*;

  localparam int PW        = $clog2(PAGES);
  localparam int MEM_BYTES = PAGES * PAGE_STD;
  localparam int MW        = $clog2(MEM_BYTES);
  localparam int CW        = $clog2(PROG_CYC + 1);
  localparam int NP        = $bits(sfp_pins_s);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, change accepted when stages 2 and 3 agree
  logic [NP-1:0] s1_q;
  logic [NP-1:0] s2_q;
  logic [NP-1:0] s3_q;
  logic [NP-1:0] f_d;
  sfp_pins_s     f_q;
  sfp_pins_s     p_q;

  for (genvar i = 0; i < NP; i++) begin : g_filt
    assign f_d[i] = (s2_q[i] == s3_q[i]) ? s2_q[i] : f_q[i];
  end

  // Idle levels keep a floating write-protect and reset inactive
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= PINS_IDLE;
      s2_q <= PINS_IDLE;
      s3_q <= PINS_IDLE;
      f_q  <= PINS_IDLE;
      p_q  <= PINS_IDLE;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q  <= f_d;
      p_q  <= f_q;
    end
  end

  // Edge detection on filtered levels only
  logic in_rst;
  logic sel;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  assign in_rst   = rst | ~f_q.reset_n;
  assign sel      = ~f_q.cs_n;
  assign cs_fall  = ~f_q.cs_n & p_q.cs_n;
  assign cs_rise  = f_q.cs_n & ~p_q.cs_n;
  assign sck_rise = f_q.sck & ~p_q.sck;
  assign sck_fall = ~f_q.sck & p_q.sck;

  ////////////////////////////////////////////////////////////////////////////
  // Main array and the two page buffers
  logic [7:0]    mem_q [MEM_BYTES];
  logic [7:0]    buf_q [2][PAGE_STD];
  logic          mw_en;
  logic [MW-1:0] mw_idx;
  logic [7:0]    mw_dat;
  logic          bw_en;
  logic          bw_sel;
  logic [8:0]    bw_idx;
  logic [7:0]    bw_dat;

  // Data arrays carry no reset; contents are undefined after power-up
  always_ff @(posedge clk) begin
    if (mw_en) begin
      mem_q[mw_idx] <= mw_dat;
    end
    if (bw_en) begin
      buf_q[bw_sel][bw_idx] <= bw_dat;
    end
  end

  // Byte index past the configured page length folds back to zero
  function automatic logic [8:0] wrap_ptr(input logic [8:0] p,
                                          input logic       b256);
    logic [9:0] lim;
    lim = b256 ? 10'(PAGE_BIN) : 10'(PAGE_STD);
    return ({1'b0, p} >= lim) ? 9'h000 : p;
  endfunction

  // Pages sit on a fixed 264-byte stride in either page size
  function automatic logic [MW-1:0] mem_idx(input logic [PW-1:0] pg,
                                            input logic [8:0]    b);
    return MW'(int'(pg) * PAGE_STD + int'(b));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Protection state and engine state visible to the frame logic
  logic             guard_en_q;
  logic             guard_en_d;
  logic [SEC_W**2-2:0] map_q;
  logic [SEC_W**2-2:0] map_d;
  logic [SEC_W**2-2:0] frz_q;
  logic [SEC_W**2-2:0] frz_d;
  sfp_eng_e         eng_q;
  sfp_eng_e         eng_d;
  logic             disc_q;
  logic             p256_q;
  logic [7:0]       sts;

  // Program or erase refused under write-protect or by sector guards
  function automatic logic blocked(input logic [PW-1:0] pg);
    logic [SEC_W-1:0] s;
    s = SEC_W'(int'(pg) / PAGES_PER_SECTOR);
    return ~f_q.wp_n | frz_q[s] | (guard_en_q & map_q[s]);
  endfunction

  always_comb begin
    sts            = 8'h00;
    sts[STS_RDY]   = (eng_q == ENG_IDLE);
    sts[STS_GUARD] = guard_en_q;
    sts[STS_DISC]  = disc_q;
    sts[STS_P256]  = p256_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame logic: opcode, address, data in and data out
  sfp_frame_e    st_q;
  sfp_frame_e    st_d;
  logic [2:0]    cnt_q;
  logic [2:0]    cnt_d;
  logic [7:0]    sh_q;
  logic [7:0]    sh_d;
  logic [7:0]    opc_q;
  logic [7:0]    opc_d;
  logic [1:0]    acnt_q;
  logic [1:0]    acnt_d;
  logic [23:0]   addr_q;
  logic [23:0]   addr_d;
  logic [7:0]    dat_q;
  logic [7:0]    dat_d;
  logic [8:0]    ptr_q;
  logic [8:0]    ptr_d;
  logic [PW-1:0] pg_q;
  logic [PW-1:0] pg_d;
  logic [2:0]    obit_q;
  logic [2:0]    obit_d;
  logic [7:0]    out_q;
  logic [7:0]    out_d;
  logic          so_q;
  logic          so_d;
  logic          oe_n_q;
  logic          oe_n_d;
  logic          disc_d;
  logic          p256_d;
  logic          exec;
  logic [7:0]    byte_in;
  logic          op_b1;
  logic          op_arr;
  logic          op_sts;

  assign op_b1  = (opc_q == OP_BUF_WR1) | (opc_q == OP_BUF_RD1)
                | (opc_q == OP_PROG1);
  assign op_arr = (opc_q == OP_ARRAY_RD);
  assign op_sts = (opc_q == OP_STATUS_RD);

  // Next state of the frame, one SCK edge at a time
  always_comb begin
    byte_in = {sh_q[6:0], f_q.si};
    st_d    = st_q;
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    opc_d   = opc_q;
    acnt_d  = acnt_q;
    addr_d  = addr_q;
    dat_d   = dat_q;
    ptr_d   = ptr_q;
    pg_d    = pg_q;
    obit_d  = obit_q;
    out_d   = out_q;
    so_d    = so_q;
    oe_n_d  = oe_n_q;
    disc_d  = disc_q;
    p256_d  = p256_q;
    exec    = 1'b0;
    bw_en   = 1'b0;
    bw_sel  = op_b1;
    bw_idx  = ptr_q;
    bw_dat  = byte_in;
    if (!sel) begin
      // Partial or discarded frames simply fall back to idle
      oe_n_d = 1'b1;
      st_d   = ST_IDLE;
      exec   = cs_rise && (st_q == ST_EXEC);
    end else if (cs_fall) begin
      st_d   = ST_OPC;
      cnt_d  = 3'h0;
      acnt_d = 2'h0;
      obit_d = 3'h0;
      p256_d = pg_size_256;
    end else if (sck_rise && (st_q == ST_OPC || st_q == ST_ADDR
                              || st_q == ST_IN)) begin
      sh_d  = byte_in;
      cnt_d = cnt_q + 3'h1;
      if (cnt_q == 3'h7 && st_q == ST_OPC) begin
        opc_d = byte_in;
        // Status reads leave the discard flag for the host to see
        if (byte_in != OP_STATUS_RD) begin
          disc_d = 1'b0;
        end
        if (eng_q == ENG_RUN && !(byte_in inside {OP_BUF_WR0, OP_BUF_WR1,
            OP_BUF_RD0, OP_BUF_RD1, OP_STATUS_RD})) begin
          st_d = ST_IGN;
        end else begin
          case (byte_in)
            OP_BUF_WR0, OP_BUF_WR1, OP_BUF_RD0, OP_BUF_RD1, OP_PROG0,
            OP_PROG1, OP_ERASE, OP_ARRAY_RD: st_d = ST_ADDR;
            OP_STATUS_RD: begin
              st_d  = ST_OUT;
              out_d = sts;
            end
            OP_GUARD_EN, OP_GUARD_DIS: st_d = ST_EXEC;
            OP_GUARD_WR, OP_FREEZE:    st_d = ST_IN;
            default:                   st_d = ST_IGN;
          endcase
        end
      end else if (cnt_q == 3'h7 && st_q == ST_ADDR) begin
        addr_d = {addr_q[15:0], byte_in};
        acnt_d = acnt_q + 2'h1;
        if (acnt_q == 2'(ADDR_BYTES - 1)) begin
          pg_d  = p256_q ? PW'(addr_d >> BIN_PAGE_LSB)
                         : PW'(addr_d >> STD_PAGE_LSB);
          ptr_d = wrap_ptr(p256_q ? {1'b0, addr_d[7:0]} : addr_d[8:0],
                           p256_q);
          if (opc_q == OP_BUF_WR0 || opc_q == OP_BUF_WR1) begin
            st_d = ST_IN;
          end else if (opc_q == OP_BUF_RD0 || opc_q == OP_BUF_RD1) begin
            st_d  = ST_OUT;
            out_d = buf_q[op_b1][ptr_d];
          end else if (op_arr) begin
            st_d  = ST_OUT;
            out_d = mem_q[mem_idx(pg_d, ptr_d)];
          end else if (blocked(pg_d)) begin
            st_d   = ST_IGN;
            disc_d = 1'b1;
          end else begin
            st_d = ST_EXEC;
          end
        end
      end else if (cnt_q == 3'h7) begin
        if (opc_q == OP_BUF_WR0 || opc_q == OP_BUF_WR1) begin
          bw_en = 1'b1;
          ptr_d = wrap_ptr(ptr_q + 9'h001, p256_q);
        end else begin
          dat_d = byte_in;
          if (opc_q == OP_GUARD_WR && !f_q.wp_n) begin
            st_d   = ST_IGN;
            disc_d = 1'b1;
          end else begin
            st_d = ST_EXEC;
          end
        end
      end
    end else if (sck_fall && st_q == ST_OUT) begin
      so_d   = out_q[3'h7 - obit_q];
      oe_n_d = 1'b0;
      obit_d = obit_q + 3'h1;
      if (obit_q == 3'h7) begin
        // Next byte fetched ahead so the following edge has it ready
        if (op_sts) begin
          out_d = sts;
        end else begin
          ptr_d = wrap_ptr(ptr_q + 9'h001, p256_q);
          if (op_arr && ptr_d == 9'h000) begin
            pg_d = pg_q + PW'(1);
          end
          out_d = op_arr ? mem_q[mem_idx(pg_d, ptr_d)]
                         : buf_q[op_b1][ptr_d];
        end
      end
    end
  end

  // Frame registers; pin reset aborts the frame as well
  always_ff @(posedge clk) begin
    if (in_rst) begin
      st_q   <= ST_IDLE;
      cnt_q  <= 3'h0;
      sh_q   <= 8'h00;
      opc_q  <= 8'h00;
      acnt_q <= 2'h0;
      addr_q <= 24'h000000;
      dat_q  <= 8'h00;
      ptr_q  <= 9'h000;
      pg_q   <= '0;
      obit_q <= 3'h0;
      out_q  <= 8'h00;
      so_q   <= 1'b0;
      oe_n_q <= 1'b1;
      disc_q <= 1'b0;
      p256_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      opc_q  <= opc_d;
      acnt_q <= acnt_d;
      addr_q <= addr_d;
      dat_q  <= dat_d;
      ptr_q  <= ptr_d;
      pg_q   <= pg_d;
      obit_q <= obit_d;
      out_q  <= out_d;
      so_q   <= so_d;
      oe_n_q <= oe_n_d;
      disc_q <= disc_d;
      p256_q <= p256_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sector protection: nonvolatile in spirit, cleared only at power-on
  always_comb begin
    guard_en_d = guard_en_q;
    map_d      = map_q;
    frz_d      = frz_q;
    if (exec) begin
      if (opc_q == OP_GUARD_EN) begin
        guard_en_d = 1'b1;
      end else if (opc_q == OP_GUARD_DIS) begin
        guard_en_d = 1'b0;
      end else if (opc_q == OP_GUARD_WR && f_q.wp_n) begin
        map_d = (map_q & frz_q) | (dat_q & ~frz_q);
      end else if (opc_q == OP_FREEZE) begin
        frz_d = frz_q | dat_q;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      guard_en_q <= 1'b0;
      map_q      <= '0;
      frz_q      <= '0;
    end else begin
      guard_en_q <= guard_en_d;
      map_q      <= map_d;
      frz_q      <= frz_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Self-timed program and erase engine, independent of select
  logic [CW-1:0] tmr_q;
  logic [CW-1:0] tmr_d;
  logic [8:0]    walk_q;
  logic [8:0]    walk_d;
  logic [PW-1:0] epg_q;
  logic [PW-1:0] epg_d;
  logic          ers_q;
  logic          ers_d;
  logic          ebuf_q;
  logic          ebuf_d;
  logic          ep256_q;
  logic          ep256_d;
  logic          stby_d;
  logic          stby_q;
  logic          busy_q;

  // One byte written per clock; the timer alone decides completion
  always_comb begin
    eng_d   = eng_q;
    tmr_d   = tmr_q;
    walk_d  = walk_q;
    epg_d   = epg_q;
    ers_d   = ers_q;
    ebuf_d  = ebuf_q;
    ep256_d = ep256_q;
    mw_en   = 1'b0;
    mw_idx  = mem_idx(epg_q, walk_q);
    mw_dat  = ers_q ? ERASED : buf_q[ebuf_q][walk_q];
    if (eng_q == ENG_IDLE) begin
      if (exec && opc_q inside {OP_PROG0, OP_PROG1, OP_ERASE}) begin
        eng_d   = ENG_RUN;
        tmr_d   = '0;
        walk_d  = 9'h000;
        epg_d   = pg_q;
        ers_d   = (opc_q == OP_ERASE);
        ebuf_d  = op_b1;
        ep256_d = p256_q;
      end
    end else begin
      tmr_d = tmr_q + CW'(1);
      if (wrap_ptr(walk_q, ep256_q) == walk_q
          && !(walk_q == 9'h000 && tmr_q != '0)) begin
        mw_en  = 1'b1;
        walk_d = walk_q + 9'h001;
      end
      if (tmr_q == CW'(PROG_CYC - 1)) begin
        eng_d = ENG_IDLE;
      end
    end
    stby_d = f_q.cs_n && (eng_d == ENG_IDLE);
  end

  always_ff @(posedge clk) begin
    if (in_rst) begin
      eng_q   <= ENG_IDLE;
      tmr_q   <= '0;
      walk_q  <= 9'h000;
      epg_q   <= '0;
      ers_q   <= 1'b0;
      ebuf_q  <= 1'b0;
      ep256_q <= 1'b0;
      stby_q  <= 1'b0;
      busy_q  <= 1'b0;
    end else begin
      eng_q   <= eng_d;
      tmr_q   <= tmr_d;
      walk_q  <= walk_d;
      epg_q   <= epg_d;
      ers_q   <= ers_d;
      ebuf_q  <= ebuf_d;
      ep256_q <= ep256_d;
      stby_q  <= stby_d;
      busy_q  <= (eng_d == ENG_RUN);
    end
  end

  assign so      = so_q;
  assign so_oe_n = oe_n_q;
  assign standby = stby_q;
  assign busy    = busy_q;

endmodule // sfp_top

// File: rtl/sfp_pkg.sv
// Constants, pin bundle and state types for the serial flash pin front end.
// Assumes a single 25 MHz system clock; all figures below are in its terms.
package sfp_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Clock and array organisation
  localparam int CLK_NS           = 40;
  localparam int NUM_PAGES        = 2048;
  localparam int PAGE_STD         = 264;
  localparam int PAGE_BIN         = 256;
  localparam int PAGES_PER_SECTOR = 256;
  localparam int NUM_SECTORS      = 8;
  localparam int SEC_W            = 3;
  localparam int ADDR_BYTES       = 3;
  localparam int STD_PAGE_LSB     = 9;
  localparam int BIN_PAGE_LSB     = 8;
  localparam logic [7:0] ERASED   = 8'hFF;

  // Self-timed program or erase cycle, least time rounded up to cycles
  localparam int PROG_TIME_NS     = 2000000;
  localparam int PROG_CYCLES      = (PROG_TIME_NS + CLK_NS - 1) / CLK_NS;

  //////////////////////////////////////////////////////////////////////////
  // Status byte bit positions
  localparam int STS_RDY          = 7;
  localparam int STS_GUARD        = 6;
  localparam int STS_DISC         = 5;
  localparam int STS_P256         = 0;

  //////////////////////////////////////////////////////////////////////////
  // Command codes
  localparam logic [7:0] OP_BUF_WR0   = 8'h21;
  localparam logic [7:0] OP_BUF_WR1   = 8'h22;
  localparam logic [7:0] OP_BUF_RD0   = 8'h23;
  localparam logic [7:0] OP_BUF_RD1   = 8'h24;
  localparam logic [7:0] OP_PROG0     = 8'h25;
  localparam logic [7:0] OP_PROG1     = 8'h26;
  localparam logic [7:0] OP_ERASE     = 8'h27;
  localparam logic [7:0] OP_ARRAY_RD  = 8'h28;
  localparam logic [7:0] OP_STATUS_RD = 8'h29;
  localparam logic [7:0] OP_GUARD_EN  = 8'h2A;
  localparam logic [7:0] OP_GUARD_DIS = 8'h2B;
  localparam logic [7:0] OP_GUARD_WR  = 8'h2C;
  localparam logic [7:0] OP_FREEZE    = 8'h2D;

  //////////////////////////////////////////////////////////////////////////
  // Pin bundle and its inactive level
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic wp_n;
    logic reset_n;
  } sfp_pins_s;

  localparam sfp_pins_s PINS_IDLE = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0,
                                      wp_n: 1'b1, reset_n: 1'b1};

  typedef enum logic [2:0] {
    ST_IDLE, ST_OPC, ST_ADDR, ST_IN, ST_OUT, ST_EXEC, ST_IGN
  } sfp_frame_e;

  typedef enum logic {ENG_IDLE, ENG_RUN} sfp_eng_e;

endpackage

// File: verification/sfp_properties.sv
// Checker: pin timing relations of the serial flash front end.
// Assumes it is bound into sfp_top and sees only that module's ports.
`timescale 1ns/1ns
module sfp_properties #(
  parameter int PROG_CYC = 1500
) (
  input logic               clk,
  input logic               rst,
  input sfp_pkg::sfp_pins_s pins,
  input logic               pg_size_256,
  input logic               so,
  input logic               so_oe_n,
  input logic               standby,
  input logic               busy
);
  import sfp_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // Length of the current busy stretch, for the self-timed cycle
  logic [31:0] busy_cnt_q;
  logic [31:0] busy_cnt_d;
  always_comb begin
    busy_cnt_d = busy ? busy_cnt_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk) begin
    busy_cnt_q <= rst ? 32'h0 : busy_cnt_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output only inside a frame, with select already low 8 cycles before
  property p_sel_opens;
    $fell(so_oe_n) |-> !pins.cs_n && !$past(pins.cs_n, 8);
  endproperty
  a_sel_opens: assert property (p_sel_opens)
    else $error("output enabled outside a frame");
  property p_sel_closes;
    $rose(pins.cs_n) |-> ##[1:7] so_oe_n;
  endproperty
  a_sel_closes: assert property (p_sel_closes)
    else $error("frame not closed after select rise");
  property p_desel_hiz;
    pins.cs_n [*8] |-> so_oe_n;
  endproperty
  a_desel_hiz: assert property (p_desel_hiz)
    else $error("output driven while deselected");
  property p_standby;
    (pins.cs_n && pins.reset_n && !busy) [*8] |-> standby;
  endproperty
  a_standby: assert property (p_standby)
    else $error("no standby while deselected and idle");
  property p_busy_no_standby;
    busy [*2] |-> !standby;
  endproperty
  a_busy_no_standby: assert property (p_busy_no_standby)
    else $error("standby during program cycle");
  property p_hw_reset;
    (!pins.reset_n) [*6] |-> !busy && so_oe_n;
  endproperty
  a_hw_reset: assert property (p_hw_reset)
    else $error("activity while reset pin low");
  // Aborted cycles are excluded by the reset pin terms
  property p_self_timed;
    $fell(busy) && $past(pins.reset_n, 6) && pins.reset_n |->
      busy_cnt_q >= 32'(PROG_CYC - 1) && busy_cnt_q <= 32'(PROG_CYC + 1);
  endproperty
  a_self_timed: assert property (p_self_timed)
    else $error("program cycle length wrong");
  property p_wp_blocks;
    (!pins.wp_n) [*8] |=> !$rose(busy);
  endproperty
  a_wp_blocks: assert property (p_wp_blocks)
    else $error("program started under write protect");
  // Sync delay puts the change some 4 to 6 cycles after the pin fall
  property p_launch_fall;
    $changed(so) && !so_oe_n && !$past(so_oe_n) |->
      $past(pins.sck, 7) && !$past(pins.sck, 4);
  endproperty
  a_launch_fall: assert property (p_launch_fall)
    else $error("output bit not launched on clock fall");
  property p_por;
    $fell(rst) && pins.cs_n |-> ##[0:2] standby;
  endproperty
  a_por: assert property (p_por)
    else $error("no standby after power-on reset");
endmodule // sfp_properties

bind sfp_top sfp_properties #(.PROG_CYC(PROG_CYC)) u_props (
  .clk(clk), .rst(rst), .pins(pins), .pg_size_256(pg_size_256),
  .so(so), .so_oe_n(so_oe_n), .standby(standby), .busy(busy));

// File: verification/sfp_host.sv
// Host model: drives select, serial clock and data, reads back so.
// Assumes clk is the device clock; pins move on its falling edge only.
`timescale 1ns/1ns
module sfp_host (
  input  logic               clk,
  input  logic               wp_n,
  input  logic               reset_n,
  input  logic               so,
  input  logic               so_oe_n,
  output sfp_pkg::sfp_pins_s pins,
  output logic [7:0]         rx_byte,
  output logic               rx_valid
);
  import sfp_pkg::*;
  logic cs_q = 1'b1;
  logic sck_q = 1'b0;
  logic si_q = 1'b0;
  initial begin
    rx_byte = 8'h00;
    rx_valid = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin bundle; SCK stands still low between xfer calls
  assign pins = '{cs_n: cs_q, sck: sck_q, si: si_q, wp_n: wp_n,
                  reset_n: reset_n};

  // Deselected data line toggles so a stale bit is never mistaken
  always @(negedge clk) begin
    if (cs_q) si_q <= ~si_q;
  end

  task automatic frame_start();
    @(negedge clk);
    cs_q = 1'b0;
    repeat (8) @(negedge clk);
  endtask

  task automatic frame_end();
    repeat (8) @(negedge clk);
    cs_q = 1'b1;
    repeat (8) @(negedge clk);
  endtask

  // One SCK pulse per bit, low 4 and high 4 cycles (320 ns)
  task automatic xfer(input logic [7:0] tx, input int nbits, input bit rd);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      si_q = tx[i];
      repeat (4) @(negedge clk);
      sck_q = 1'b1;
      repeat (4) @(negedge clk);
      r[i] = so_oe_n ? ~so : so; // Floating line reads as garbage
      sck_q = 1'b0;
    end
    if (rd) begin
      rx_byte = r;
      rx_valid = 1'b1;
      @(negedge clk);
      rx_valid = 1'b0;
    end
  endtask
endmodule // sfp_host

// File: verification/testbench.sv
// Testbench: host model drives the pins, a monitor scores read bytes.
// Assumes sfp_top with a shortened program time and a 25 MHz clock.
`timescale 1ns/1ns
module testbench;
  import sfp_pkg::*;
  localparam int PROG = 1500;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       pg = 1'b0;
  logic       wp_n = 1'b1;
  logic       reset_n = 1'b1;
  sfp_pins_s  pins;
  logic       so;
  logic       so_oe_n;
  logic       standby;
  logic       busy;
  logic [7:0] rx_byte;
  logic       rx_valid;
  logic [7:0] exp_q[$];
  logic [7:0] msk_q[$];
  logic [7:0] d[4];
  int         n_fail = 0;
  int         n_compared = 0;

  always #20 clk = ~clk;

  sfp_top #(.PROG_CYC(PROG)) dut (.clk(clk), .rst(rst), .pins(pins),
    .pg_size_256(pg), .so(so), .so_oe_n(so_oe_n), .standby(standby),
    .busy(busy));
  sfp_host host (.clk(clk), .wp_n(wp_n), .reset_n(reset_n), .so(so),
    .so_oe_n(so_oe_n), .pins(pins), .rx_byte(rx_byte),
    .rx_valid(rx_valid));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Every read byte is scored against the oldest note, masked
  always @(posedge clk) begin
    if (rx_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(rx_byte, ~rx_byte);
      else chk(rx_byte & msk_q.pop_front(), exp_q.pop_front());
    end
  end

  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input bit ad);
    host.frame_start();
    host.xfer(op, 8, 1'b0);
    if (ad) for (int i = 2; i >= 0; i--) host.xfer(a[i*8 +: 8], 8, 1'b0);
  endtask

  task automatic rd(input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    host.xfer(8'h00, 8, 1'b1);
  endtask

  // Status twice in one frame, then select rise must float the output
  task automatic status(input logic [7:0] e, input logic [7:0] m);
    cmd(OP_STATUS_RD, 24'h0, 1'b0);
    rd(e, m);
    rd(e, m);
    chk({7'h00, so_oe_n}, 8'h00);
    host.frame_end();
    chk({7'h00, so_oe_n}, 8'h01);
  endtask

  task automatic wr1(input logic [7:0] op, input logic [7:0] v);
    cmd(op, 24'h0, 1'b0);
    host.xfer(v, 8, 1'b0);
    host.frame_end();
  endtask

  task automatic wait_busy(input logic v, input int lim);
    int n;
    n = 0;
    while (busy !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (busy !== v) begin
      n_fail++;
      $display("MISMATCH t=%0t busy seen %h expected %h", $time, busy, v);
      results();
    end
  endtask

  // Program a page, then see that no cycle starts
  task automatic prog_blocked(input logic [23:0] a);
    cmd(OP_PROG0, a, 1'b1);
    host.frame_end();
    repeat (20) @(negedge clk);
    chk({7'h00, busy}, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(56042));
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    chk({7'h00, standby}, 8'h01);
    chk({7'h00, so_oe_n}, 8'h01);
    for (int m = 1; m >= 0; m--) begin
      pg = m[0];
      status(8'h80 | 8'(m), 8'hFF);
    end
    // Buffer write across the 264-byte wrap, then read back
    for (int i = 0; i < 4; i++) d[i] = 8'($urandom());
    cmd(OP_BUF_WR0, 24'd262, 1'b1);
    for (int i = 0; i < 4; i++) host.xfer(d[i], 8, 1'b0);
    host.frame_end();
    cmd(OP_BUF_RD0, 24'd262, 1'b1);
    for (int i = 0; i < 4; i++) rd(d[i], 8'hFF);
    host.frame_end();
    // Program; second buffer stays usable while the cycle runs
    cmd(OP_PROG0, 24'(300 * 512), 1'b1);
    host.frame_end();
    wait_busy(1'b1, 40);
    chk({7'h00, standby}, 8'h00);
    cmd(OP_BUF_WR1, 24'h0, 1'b1);
    host.xfer(8'h00, 8, 1'b0);
    host.frame_end();
    host.xfer(d[3], 8, 1'b0);
    cmd(OP_BUF_RD1, 24'h0, 1'b1);
    rd(8'h00, 8'hFF);
    host.frame_end();
    status(8'h00, 8'h80);
    chk({7'h00, busy}, 8'h01);
    wait_busy(1'b0, PROG + 100);
    // Erase the next page so the array read can run into it
    cmd(OP_ERASE, 24'(301 * 512), 1'b1);
    host.frame_end();
    wait_busy(1'b1, 40);
    wait_busy(1'b0, PROG + 100);
    cmd(OP_ARRAY_RD, 24'(300 * 512 + 262), 1'b1);
    rd(d[0], 8'hFF);
    rd(d[1], 8'hFF);
    rd(ERASED, 8'hFF);
    host.frame_end();
    // Guard map set, then write protect shields sector 0
    wr1(OP_GUARD_WR, 8'h01);
    wp_n = 1'b0;
    repeat (8) @(negedge clk);
    prog_blocked(24'(5 * 512));
    status(8'hA0, 8'hFF);
    wr1(OP_GUARD_WR, 8'h00);
    cmd(OP_GUARD_EN, 24'h0, 1'b0);
    host.frame_end();
    wr1(OP_FREEZE, 8'h08);
    status(8'hC0, 8'hC0);
    wp_n = 1'b1;
    repeat (8) @(negedge clk);
    prog_blocked(24'(5 * 512));
    cmd(OP_GUARD_DIS, 24'h0, 1'b0);
    host.frame_end();
    prog_blocked(24'(768 * 512));
    // Partial opcode must leave guard enable off
    host.frame_start();
    host.xfer(OP_GUARD_EN, 4, 1'b0);
    host.frame_end();
    status(8'h80, 8'hC0);
    // Binary page size: buffer index folds back after byte 255
    pg = 1'b1;
    cmd(OP_BUF_WR0, 24'd255, 1'b1);
    host.xfer(d[2], 8, 1'b0);
    host.xfer(d[3], 8, 1'b0);
    host.frame_end();
    cmd(OP_BUF_RD0, 24'd255, 1'b1);
    rd(d[2], 8'hFF);
    rd(d[3], 8'hFF);
    rd(d[3], 8'hFF);
    host.frame_end();
    // Reset pin aborts a running cycle
    cmd(OP_PROG1, 24'(600 * 512), 1'b1);
    host.frame_end();
    wait_busy(1'b1, 40);
    reset_n = 1'b0;
    repeat (8) @(negedge clk);
    chk({6'h00, busy, so_oe_n}, 8'h01);
    reset_n = 1'b1;
    repeat (8) @(negedge clk);
    status(8'h80, 8'h80);
    results();
  end
endmodule // testbench
